// >>> hw/pm_wake_ctrl.sv
// wake-up controller for the power-managed modes
// interrupt, watchdog and reset inputs are synchronous to CORE_CLK_IN
`timescale 1ns/1ns
`include "pm_wake_consts.svh"
module pm_wake_ctrl #(
	parameter int OST_CYC = `OST_CYC_DEFAULT,
	parameter int PLL_CYC = `PLL_EXTRA_CYC
) (
	// clock and reset
	input wire logic CORE_CLK_IN,
	input wire logic ARST_N_IN,
	// mode and configuration
	input wire logic PM_ACTIVE_IN,
	input wire logic PM_IDLE_IN,
	input wire pm_wake_pkg::pm_mode_e PM_MODE_IN,
	input wire pm_wake_pkg::osc_mode_e PRI_OSC_IN,
	input wire logic TWO_SPEED_EN_IN,
	// wake sources
	input wire logic [7:0] INT_FLAG_IN,
	input wire logic [7:0] INT_CONTROL_EN_IN,
	input wire logic [7:0] PERIPH_INT_EN_IN,
	input wire logic GLOBAL_INT_EN_IN,
	input wire logic WDT_TIMEOUT_IN,
	input wire logic RESET_EVENT_IN,
	// status and clock steering
	output logic PRIMARY_CLOCK_READY_FLAG_OUT,
	output logic INTERNAL_OSC_BLOCK_STABLE_FLAG_OUT,
	output logic WAKE_OUT,
	output logic VECTOR_OUT,
	output logic WDT_RESET_OUT,
	output logic CPU_RUN_OUT,
	output pm_wake_pkg::clk_sel_e CPU_CLK_SEL_OUT,
	output pm_wake_pkg::clk_sel_e PERIPH_CLK_SEL_OUT,
	output logic [7:0] OSC_CONTROL_OUT
);
	import pm_wake_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_RUN = 4'h1,
		ST_LOW = 4'h2,
		ST_INT_EXIT = 4'h4,
		ST_RST_EXIT = 4'h8
	} state_e;
	state_e state;
	pm_mode_e mode_held;
	logic fixed_done;
	logic pri_done;
	logic timer_start;
	cnt_t next_pri_load;

	function automatic logic crystal_type(input osc_mode_e m);
		crystal_type = (m == OSC_LOW_POWER_CRYSTAL) || (m == OSC_CRYSTAL) ||
			(m == OSC_HIGH_SPEED_CRYSTAL) || (m == OSC_FAST_CRYSTAL_PLL);
	endfunction

	// only enabled sources count
	logic int_wake;
	assign int_wake = |(INT_FLAG_IN & (INT_CONTROL_EN_IN | PERIPH_INT_EN_IN));
	logic in_low;
	assign in_low = (state == ST_LOW);

	// primary start-up delay per mode and oscillator
	always_comb begin
		next_pri_load = 16'h0000;
		if (mode_held == PM_PRIMARY_IDLE_MODE)
			next_pri_load = 16'h0000;
		else if (PRI_OSC_IN == OSC_FAST_CRYSTAL_PLL)
			next_pri_load = 16'(OST_CYC + PLL_CYC);
		else if (crystal_type(PRI_OSC_IN))
			next_pri_load = 16'(OST_CYC);
		else if (PRI_OSC_IN == OSC_INTERNAL_BLOCK &&
			mode_held == PM_RC_IDLE)
			next_pri_load = 16'h0000; // no delay internal to internal
	end

	assign timer_start = in_low && (int_wake || WDT_TIMEOUT_IN) ||
		(state != ST_RST_EXIT && RESET_EVENT_IN);

	// fixed cpu-prepare delay, runs concurrently
	pm_delay_timer fixed_timer (
		.clk(CORE_CLK_IN),
		.arst_n(ARST_N_IN),
		.start(timer_start),
		.load(16'(`FIXED_DELAY_CYC)),
		.done(fixed_done)
	);
	logic fixed_seen;
	logic [15:0] pri_cnt;
	logic pri_run;

	// primary oscillator start-up counter
	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			pri_cnt <= 16'h0000;
			pri_run <= 1'b0;
			pri_done <= 1'b0;
		end else if (timer_start) begin
			pri_cnt <= RESET_EVENT_IN ? 16'(crystal_type(PRI_OSC_IN) ?
				OST_CYC : 0) : next_pri_load;
			pri_run <= 1'b1;
			pri_done <= 1'b0;
		end else if (pri_run) begin
			if (pri_cnt == 16'h0000) begin
				pri_run <= 1'b0;
				pri_done <= 1'b1;
			end else
				pri_cnt <= pri_cnt - 16'h0001;
		end else
			pri_done <= 1'b0;
	end

	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN)
			fixed_seen <= 1'b0;
		else if (timer_start)
			fixed_seen <= 1'b0;
		else if (fixed_done)
			fixed_seen <= 1'b1;
	end

	// ----------------------------------------
	// exit sequencing
	// ----------------------------------------
	logic pri_ready_seen;
	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN)
			pri_ready_seen <= 1'b0;
		else if (timer_start)
			pri_ready_seen <= 1'b0;
		else if (pri_done)
			pri_ready_seen <= 1'b1;
	end

	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			state <= ST_RUN;
			mode_held <= PM_SLEEP;
			WAKE_OUT <= 1'b0;
			VECTOR_OUT <= 1'b0;
			WDT_RESET_OUT <= 1'b0;
		end else begin
			WAKE_OUT <= 1'b0;
			VECTOR_OUT <= 1'b0;
			WDT_RESET_OUT <= 1'b0;
			if (RESET_EVENT_IN && state != ST_RST_EXIT) begin
				state <= ST_RST_EXIT; // any reset ends a mode
			end else begin
				unique case (state)
					ST_RUN: begin
						mode_held <= PM_MODE_IN;
						if (PM_ACTIVE_IN && PM_IDLE_IN)
							state <= ST_LOW;
						// watchdog in run mode resets
						if (WDT_TIMEOUT_IN)
							WDT_RESET_OUT <= 1'b1;
					end
					ST_LOW: begin
						// nothing but these, or a reset, ends the mode
						if (int_wake || WDT_TIMEOUT_IN) begin
							state <= ST_INT_EXIT;
							WAKE_OUT <= 1'b1;
							// vector only with global enable
							VECTOR_OUT <= int_wake && GLOBAL_INT_EN_IN;
						end
					end
					ST_INT_EXIT: begin
						if ((pri_done || pri_ready_seen) &&
							(fixed_done || fixed_seen))
							state <= ST_RUN;
					end
					ST_RST_EXIT: begin
						if (pri_done || pri_ready_seen)
							state <= ST_RUN;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// clock steering and ready flags
	// ----------------------------------------
	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			CPU_CLK_SEL_OUT <= CLK_NONE;
			PERIPH_CLK_SEL_OUT <= CLK_NONE;
			CPU_RUN_OUT <= 1'b0;
		end else unique case (state)
			ST_RUN: begin
				CPU_CLK_SEL_OUT <= CLK_PRIMARY;
				PERIPH_CLK_SEL_OUT <= CLK_PRIMARY;
				CPU_RUN_OUT <= 1'b1;
			end
			ST_LOW: begin
				CPU_CLK_SEL_OUT <= CLK_NONE;
				PERIPH_CLK_SEL_OUT <= (mode_held == PM_PRIMARY_IDLE_MODE) ?
					CLK_PRIMARY : CLK_PM;
				CPU_RUN_OUT <= 1'b0;
			end
			ST_INT_EXIT: begin
				// primary idle keeps primary; others stay on pm clock
				CPU_CLK_SEL_OUT <= (mode_held == PM_PRIMARY_IDLE_MODE) ?
					CLK_PRIMARY : CLK_PM;
				PERIPH_CLK_SEL_OUT <= (mode_held == PM_PRIMARY_IDLE_MODE) ?
					CLK_PRIMARY : CLK_PM;
				CPU_RUN_OUT <= fixed_done || fixed_seen;
			end
			ST_RST_EXIT: begin
				// two-speed start runs on internal osc
				CPU_CLK_SEL_OUT <= TWO_SPEED_EN_IN ? CLK_INTERNAL : CLK_NONE;
				PERIPH_CLK_SEL_OUT <= TWO_SPEED_EN_IN ? CLK_INTERNAL : CLK_NONE;
				CPU_RUN_OUT <= TWO_SPEED_EN_IN;
			end
		endcase
	end

	// flag rises with the switch back to primary
	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			PRIMARY_CLOCK_READY_FLAG_OUT <= 1'b0;
			INTERNAL_OSC_BLOCK_STABLE_FLAG_OUT <= 1'b0;
		end else if (state == ST_RUN) begin
			PRIMARY_CLOCK_READY_FLAG_OUT <= crystal_type(PRI_OSC_IN);
			INTERNAL_OSC_BLOCK_STABLE_FLAG_OUT <= (PRI_OSC_IN == OSC_INTERNAL_BLOCK);
		end else begin
			PRIMARY_CLOCK_READY_FLAG_OUT <= 1'b0;
			INTERNAL_OSC_BLOCK_STABLE_FLAG_OUT <= 1'b0;
		end
	end

	// every reset clears oscillator control
	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN)
			OSC_CONTROL_OUT <= `OSC_CTRL_RESET;
		else if (RESET_EVENT_IN)
			OSC_CONTROL_OUT <= `OSC_CTRL_RESET;
		else
			OSC_CONTROL_OUT <= OSC_CONTROL_OUT;
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (!ARST_N_IN);

	no_stray_wake_a: assert property (in_low && !int_wake && !WDT_TIMEOUT_IN &&
		!RESET_EVENT_IN |=> state == ST_LOW)
		else $error("low-power mode left without a trigger");
	masked_int_a: assert property (in_low && !WDT_TIMEOUT_IN && !RESET_EVENT_IN
		&& (INT_FLAG_IN & (INT_CONTROL_EN_IN | PERIPH_INT_EN_IN)) == 8'h00
		|=> !WAKE_OUT)
		else $error("disabled interrupt woke the device");
	wake_start_a: assert property (in_low && int_wake && !RESET_EVENT_IN
		|=> WAKE_OUT && state == ST_INT_EXIT)
		else $error("exit did not start on enabled flag");
	vector_gie_a: assert property (in_low && int_wake && !RESET_EVENT_IN
		|=> VECTOR_OUT == $past(GLOBAL_INT_EN_IN))
		else $error("vector does not follow global enable");
	primary_idle_mode_clk_a: assert property (state == ST_INT_EXIT &&
		mode_held == PM_PRIMARY_IDLE_MODE |=> CPU_CLK_SEL_OUT == CLK_PRIMARY)
		else $error("primary idle exit not on primary clock");
	other_idle_clk_a: assert property (state == ST_INT_EXIT &&
		mode_held != PM_PRIMARY_IDLE_MODE |=> CPU_CLK_SEL_OUT == CLK_PM)
		else $error("idle exit left the power-managed clock");
	reset_unclocked_a: assert property (state == ST_RST_EXIT &&
		!TWO_SPEED_EN_IN |=> !CPU_RUN_OUT)
		else $error("cpu ran during reset exit");
	fixed_delay_a: assert property (in_low && int_wake && !RESET_EVENT_IN
		|=> !CPU_RUN_OUT [*8])
		else $error("cpu resumed before fixed delay");
	wdt_run_reset_a: assert property (state == ST_RUN && WDT_TIMEOUT_IN &&
		!RESET_EVENT_IN |=> WDT_RESET_OUT)
		else $error("watchdog in run mode gave no reset");
	osc_clear_a: assert property (RESET_EVENT_IN |=>
		OSC_CONTROL_OUT == 8'h00)
		else $error("reset left oscillator control set");
	ready_flag_a: assert property (PRIMARY_CLOCK_READY_FLAG_OUT |->
		crystal_type($past(PRI_OSC_IN)))
		else $error("ready flag for non-crystal primary");

	int_wake_c: cover property (in_low ##1 state == ST_INT_EXIT ##[1:300]
		state == ST_RUN);
	reset_exit_c: cover property (state == ST_RST_EXIT ##[1:300]
		state == ST_RUN);
	wdt_reset_c: cover property (WDT_RESET_OUT);
endmodule

// >>> hw/pm_wake_consts.svh
// constants for the power-mode wake-up controller
// assumes a 10 MHz core clock; included by bare name
`ifndef PM_WAKE_CONSTS_SVH
`define PM_WAKE_CONSTS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 100
`define FIXED_DELAY_NS 10000
`define PLL_EXTRA_NS 2000000
`define FIXED_DELAY_CYC ((`FIXED_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PLL_EXTRA_CYC ((`PLL_EXTRA_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OST_CYC_DEFAULT 1024

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define GIE_BIT 7
`define INT_WIDTH 8
`define OSC_CTRL_RESET 8'h00
`define CNT_WIDTH 16

`endif

// >>> hw/pm_wake_pkg.sv
// types for the power-mode wake-up controller
// no dependencies
package pm_wake_pkg;
	typedef enum logic [1:0] {
		PM_PRIMARY_IDLE_MODE = 2'h0,
		PM_SEC_IDLE = 2'h1,
		PM_RC_IDLE = 2'h2,
		PM_SLEEP = 2'h3
	} pm_mode_e;
	typedef enum logic [2:0] {
		OSC_LOW_POWER_CRYSTAL = 3'h0,
		OSC_CRYSTAL = 3'h1,
		OSC_HIGH_SPEED_CRYSTAL = 3'h2,
		OSC_FAST_CRYSTAL_PLL = 3'h3,
		OSC_EXTERNAL_CLOCK = 3'h4,
		OSC_RES_CAP = 3'h5,
		OSC_LOW_FREQ_INTERNAL = 3'h6,
		OSC_INTERNAL_BLOCK = 3'h7
	} osc_mode_e;
	typedef enum logic [1:0] {
		CLK_NONE = 2'h0,
		CLK_PRIMARY = 2'h1,
		CLK_PM = 2'h2,
		CLK_INTERNAL = 2'h3
	} clk_sel_e;
	typedef logic [15:0] cnt_t;
endpackage

// >>> hw/pm_delay_timer.sv
// down-counter that times one exit delay
// loaded on start, done is a registered one-cycle pulse
`timescale 1ns/1ns
`include "pm_wake_consts.svh"
module pm_delay_timer (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic start,
	input wire pm_wake_pkg::cnt_t load,
	output logic done
);
	import pm_wake_pkg::*;
	cnt_t count;
	logic running;

	// delays expressed as cycle counts
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			count <= 16'h0000;
			running <= 1'b0;
			done <= 1'b0;
		end else if (start) begin
			count <= load;
			running <= (load != 16'h0000);
			done <= (load == 16'h0000);
		end else if (running) begin
			count <= count - 16'h0001;
			if (count <= 16'h0001) begin
				running <= 1'b0;
				done <= 1'b1;
			end
		end else begin
			done <= 1'b0;
		end
	end

	timer_done_pulse_a: assert property (@(posedge clk) disable iff (!arst_n)
		done && !start |=> !done || start)
		else $error("timer done held longer than one cycle");
endmodule

// >>> verif/pm_source_model.sv
// far-side model: interrupt sources, watchdog and reset logic
// assumes the bench drives its requests at the falling clock edge
`timescale 1ns/1ns
module pm_source_model (
	// clock
	input wire logic clk,
	// requests from the bench
	input wire logic [7:0] int_req,
	input wire logic wdt_req,
	input wire logic rst_req,
	// lines into the controller
	output logic [7:0] int_flag,
	output logic wdt_out,
	output logic rst_out
);
	initial begin
		int_flag = 8'h00;
		wdt_out = 1'b0;
		rst_out = 1'b0;
	end
	// --------------------------------
	// source lines
	// --------------------------------
	// moved on the falling edge, clear of the controller's sampling edge
	// one step late, so the bench's request of this edge is always seen
	always @(negedge clk) begin
		#1;
		int_flag <= int_req;
		wdt_out <= wdt_req;
		rst_out <= rst_req;
	end
endmodule

// >>> verif/pm_wake_ctrl_tb.sv
// self-checking bench for the power-mode wake-up controller
// assumes a 10 MHz clock and shortened start-up counts
`timescale 1ns/1ns
module pm_wake_ctrl_tb;
	import pm_wake_pkg::*;
	logic clk, arst_n, act, idle, two, gie, wdt_req, rst_req, wdt, rst;
	logic wake, vec, wdt_rst, cpu_run, pri_rdy, osc_rdy;
	logic [7:0] int_req, flg, en_c, en_p, osc_ctl;
	pm_mode_e mode;
	osc_mode_e osc;
	clk_sel_e cpu_sel, per_sel;
	int n_fail = 0, check_count = 0, n_wake = 0, n_wdtr = 0, n, m;
	// start-up counts long enough to stand out from the fixed delay
	localparam int OSCILLATOR_STARTUP_TIMER = 200;
	localparam int PLL = 300;
	pm_source_model i_src (.clk(clk), .int_req(int_req),
		.wdt_req(wdt_req), .rst_req(rst_req), .int_flag(flg),
		.wdt_out(wdt), .rst_out(rst));
	pm_wake_ctrl #(.OST_CYC(OSCILLATOR_STARTUP_TIMER), .PLL_CYC(PLL)) i_dut (.CORE_CLK_IN(clk),
		.ARST_N_IN(arst_n), .PM_ACTIVE_IN(act), .PM_IDLE_IN(idle),
		.PM_MODE_IN(mode), .PRI_OSC_IN(osc), .TWO_SPEED_EN_IN(two),
		.INT_FLAG_IN(flg), .INT_CONTROL_EN_IN(en_c),
		.PERIPH_INT_EN_IN(en_p), .GLOBAL_INT_EN_IN(gie),
		.WDT_TIMEOUT_IN(wdt), .RESET_EVENT_IN(rst),
		.PRIMARY_CLOCK_READY_FLAG_OUT(pri_rdy),
		.INTERNAL_OSC_BLOCK_STABLE_FLAG_OUT(osc_rdy), .WAKE_OUT(wake),
		.VECTOR_OUT(vec), .WDT_RESET_OUT(wdt_rst), .CPU_RUN_OUT(cpu_run),
		.CPU_CLK_SEL_OUT(cpu_sel), .PERIPH_CLK_SEL_OUT(per_sel),
		.OSC_CONTROL_OUT(osc_ctl));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// pulses are counted so none slips between bench samples
	always @(posedge clk) begin
		if (wake === 1'b1)
			n_wake++;
		if (wdt_rst === 1'b1)
			n_wdtr++;
	end
	// --------------------------------
	// tasks
	// --------------------------------
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, got);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(negedge clk);
	endtask
	function automatic logic pick(input int k);
		case (k)
			0: return wake;
			1: return cpu_run;
			2: return pri_rdy;
			default: return osc_rdy;
		endcase
	endfunction
	// bounded wait, n is the cycles taken
	task automatic wait_for(input int k, output int cyc);
		cyc = 0;
		while (pick(k) !== 1'b1) begin
			tick(1);
			cyc++;
			if (cyc > 3000) begin
				n_fail++;
				$display("Error wait %0d expected 1 seen 0", k);
				close_out;
			end
		end
	endtask
	task automatic enter(input pm_mode_e m);
		mode = m;
		act = 1'b1;
		idle = 1'b1;
		tick(3);
	endtask
	task automatic leave;
		act = 1'b0;
		idle = 1'b0;
		int_req = 8'h00;
	endtask
	// --------------------------------
	// main sequence
	// --------------------------------
	initial begin
		arst_n = 1'b0;
		{act, idle, two, gie, wdt_req, rst_req} = 6'h00;
		{int_req, en_c, en_p} = 24'h000000;
		mode = PM_SLEEP;
		osc = OSC_CRYSTAL;
		tick(20);
		arst_n = 1'b1;
		tick(2);
		chk("osc ctrl", 8'h00, osc_ctl);
		chk("run", 8'h01, {7'h00, cpu_run});
		chk("ready", 8'h01, {7'h00, pri_rdy});
		// disabled source must not wake, enabled one must
		enter(PM_SLEEP);
		int_req = 8'h01;
		tick(20);
		chk("no wake", 8'h00, 8'(n_wake));
		gie = 1'b1;
		en_c = 8'h01;
		wait_for(0, n);
		chk("wake lag", 8'h01, {7'h00, n <= 3});
		chk("vector", 8'h01, {7'h00, vec});
		leave;
		wait_for(1, n);
		chk("run delay", 8'h01, {7'h00, n >= 97});
		m = n;
		wait_for(2, n);
		chk("ost delay", 8'h01, {7'h00, m + n >= OSCILLATOR_STARTUP_TIMER && m + n <= OSCILLATOR_STARTUP_TIMER + 4});
		chk("cpu sel", {6'h00, CLK_PRIMARY}, {6'h00, cpu_sel});
		// peripheral enable, global enable clear, rc idle
		osc = OSC_INTERNAL_BLOCK;
		{gie, en_c, en_p} = {1'b0, 8'h00, 8'h80};
		enter(PM_RC_IDLE);
		int_req = 8'h80;
		wait_for(0, n);
		chk("no vector", 8'h00, {7'h00, vec});
		leave;
		tick(5);
		chk("idle clk", {6'h00, CLK_PM}, {6'h00, cpu_sel});
		chk("idle per", {6'h00, CLK_PM}, {6'h00, per_sel});
		wait_for(3, n);
		chk("pri flag", 8'h00, {7'h00, pri_rdy});
		// primary idle keeps the primary clock
		osc = OSC_CRYSTAL;
		enter(PM_PRIMARY_IDLE_MODE);
		int_req = 8'h80;
		wait_for(0, n);
		leave;
		tick(2);
		chk("pri cpu", {6'h00, CLK_PRIMARY}, {6'h00, cpu_sel});
		chk("pri per", {6'h00, CLK_PRIMARY}, {6'h00, per_sel});
		wait_for(1, n);
		// watchdog: reset in run, wake in sleep
		tick(2);
		wdt_req = 1'b1;
		tick(1);
		wdt_req = 1'b0;
		tick(3);
		chk("wdt reset", 8'h01, 8'(n_wdtr));
		gie = 1'b1;
		osc = OSC_FAST_CRYSTAL_PLL;
		enter(PM_SLEEP);
		wdt_req = 1'b1;
		tick(1);
		wdt_req = 1'b0;
		wait_for(0, n);
		chk("wdt vector", 8'h00, {7'h00, vec});
		leave;
		wait_for(2, n);
		chk("pll delay", 8'h01, {7'h00, n >= OSCILLATOR_STARTUP_TIMER + PLL && n <= OSCILLATOR_STARTUP_TIMER + PLL + 4});
		// reset exit with and without two-speed start-up
		osc = OSC_FAST_CRYSTAL_PLL;
		for (int t = 1; t >= 0; t--) begin
			two = t[0];
			enter(PM_SLEEP);
			leave;
			rst_req = 1'b1;
			tick(1);
			rst_req = 1'b0;
			tick(4);
			chk("rst run", {7'h00, two}, {7'h00, cpu_run});
			chk("rst sel", two ? 8'h03 : 8'h00, {6'h00, cpu_sel});
			chk("rst osc", 8'h00, osc_ctl);
			wait_for(2, n);
			chk("rst ready", 8'h01, {7'h00, cpu_run});
		end
		chk("wake count", 8'h04, 8'(n_wake));
		close_out;
	end
endmodule
